/* File: bench/lam_drive_model.sv */
// drive-side model: makes inrush contact closures for the life counter
`timescale 1ns/1ns
module lam_drive_model (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        rst,
  // closure request
  input  wire logic        go,
  input  wire logic [15:0] closures,
  // contact and progress
  output logic             contact,
  output logic             busy
);
  logic [15:0] left;
  logic [1:0]  phase;
  // two cycles closed, two open, so each closure clears the pin synchroniser
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      left <= 16'h0;
      phase <= 2'h0;
    end else if (go) begin
      left <= closures;
      phase <= 2'h0;
    end else if (left != 16'h0) begin
      phase <= phase + 2'h1;
      if (phase == 2'h3) begin
        left <= left - 16'h1;
      end
    end
  end
  assign contact = (left != 16'h0) && !phase[1];
  assign busy    = (left != 16'h0);
endmodule // lam_drive_model

/* File: bench/lam_top_tb_top.sv */
// self-checking bench for the life alarm monitor over AXI4-Lite
`timescale 1ns/1ns
module lam_top_tb_top;
  localparam int unsigned DC_CYC = 20;
  logic                  clock, rst, go, contact, busy, energizeTick, lifeAlarmOutput, dcInjectEnable, irq;
  logic                  s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic                  s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0]            s_axi_awaddr, s_axi_araddr, heatsinkTemp;
  logic [31:0]           s_axi_wdata, s_axi_rdata;
  logic [3:0]            s_axi_wstrb;
  logic [1:0]            s_axi_bresp, s_axi_rresp;
  logic [6:0]            capMeasPercent;
  logic [2:0]            terminalOut;
  lam_pkg::lam_pins_type pinReg, pins, base;
  int                    errTotal, checkCount, n;

  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  always_comb begin
    pins = pinReg;
    pins.inrushContact = contact;
  end

  lam_top #(.DC_APPLY_CYCLES(DC_CYC)) lam_top_i (
    .clock(clock), .rst(rst), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .pinsAsync(pins), .heatsinkTemp(heatsinkTemp), .energizeTick(energizeTick),
    .capMeasPercent(capMeasPercent), .lifeAlarmOutput(lifeAlarmOutput), .terminalOut(terminalOut),
    .dcInjectEnable(dcInjectEnable), .irq(irq));
  lam_drive_model lam_drive_model_i (.clock(clock), .rst(rst), .go(go), .closures(16'h2710),
    .contact(contact), .busy(busy));

  task automatic wrapUp;
    $display("checks %0d mismatches %0d", checkCount, errTotal);
    if (errTotal == 0 && checkCount > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checkCount++;
    if (got !== exp) begin
      errTotal++;
      $display("Error t=%0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tmo;
    errTotal++;
    $display("Error t=%0t wait timed out", $time);
    wrapUp();
  endtask
  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = lam_pkg::RESP_OKAY);
    logic done;
    done = 1'b0;
    @(posedge clock);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (int k = 0; k < 50 && !done; k++) begin
      @(posedge clock);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1) begin
        done = 1'b1;
        s_axi_bready <= 1'b0;
        chk({30'h0, s_axi_bresp}, {30'h0, er});
      end
    end
    if (!done) tmo();
  endtask
  task automatic axr(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er = lam_pkg::RESP_OKAY);
    logic done;
    done = 1'b0;
    @(posedge clock);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (int k = 0; k < 50 && !done; k++) begin
      @(posedge clock);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1) begin
        done = 1'b1;
        s_axi_rready <= 1'b0;
        chk(s_axi_rdata, ed);
        chk({30'h0, s_axi_rresp}, {30'h0, er});
      end
    end
    if (!done) tmo();
  endtask
  task automatic tick(input int k);
    repeat (k) begin
      @(posedge clock);
      energizeTick <= 1'b1;
      @(posedge clock);
      energizeTick <= 1'b0;
    end
  endtask
  // one whole host measurement; the dc window is counted, not waited on
  task automatic meas(input logic [6:0] pct, input logic [31:0] st);
    int cnt;
    cnt = 0;
    capMeasPercent <= pct;
    axw(lam_pkg::ADDR_MEASURE, 32'h1);
    axr(lam_pkg::ADDR_MEASURE, 32'h1);
    pinReg.powerPresent <= 1'b0; // off time shortened: bench has no cooling model
    repeat (60) begin
      @(posedge clock);
      if (dcInjectEnable === 1'b1) cnt++;
    end
    checkCount++;
    if (cnt < DC_CYC || cnt > DC_CYC + 1) begin
      errTotal++;
      $display("Error t=%0t dc window lasted %0d cycles", $time, cnt);
    end
    pinReg.powerPresent <= 1'b1;
    repeat (4) @(posedge clock);
    axr(lam_pkg::ADDR_MEASURE, 32'h3);
    axr(lam_pkg::ADDR_MAIN_CAP, {25'h0, pct});
    axr(lam_pkg::ADDR_STATUS, st);
  endtask

  initial begin
    errTotal = 0;
    checkCount = 0;
    rst = 1'b1;
    {go, energizeTick, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 7'h0;
    {s_axi_awaddr, s_axi_araddr, heatsinkTemp} = 24'h0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hF;
    capMeasPercent = 7'h64;
    base = '0;
    base.powerPresent = 1'b1;
    base.motorConnected = 1'b1;
    pinReg = base;
    repeat (8) @(posedge clock);
    rst <= 1'b0;
    repeat (4) @(posedge clock);
    axr(lam_pkg::ADDR_STATUS, 32'h0);
    axr(lam_pkg::ADDR_INRUSH, 32'h64);
    axr(lam_pkg::ADDR_CTRL_CAP, 32'h64);
    axr(lam_pkg::ADDR_MAIN_CAP, 32'h64);
    axr(lam_pkg::ADDR_MEASURE, 32'h0);
    axr(8'h40, 32'h0, lam_pkg::RESP_SLVERR);
    axw(8'h40, 32'h1, lam_pkg::RESP_SLVERR);
    $display("test reset values done");
    axw(lam_pkg::ADDR_TERM_SEL, {16'h0, lam_pkg::SEL_SINK, lam_pkg::SEL_SOURCE});
    repeat (2) @(posedge clock);
    chk({29'h0, terminalOut}, 32'h2);
    axw(lam_pkg::ADDR_IRQ_ENABLE, 32'h4);
    pinReg.fanFault <= 1'b1;
    for (n = 0; n < 20 && lifeAlarmOutput !== 1'b1; n++) @(posedge clock);
    repeat (2) @(posedge clock);
    chk({31'h0, lifeAlarmOutput}, 32'h1);
    chk({29'h0, terminalOut}, 32'h1);
    chk({31'h0, irq}, 32'h1);
    axr(lam_pkg::ADDR_STATUS, 32'h4);
    axw(lam_pkg::ADDR_IRQ_ENABLE, 32'h0);
    repeat (2) @(posedge clock);
    chk({31'h0, irq}, 32'h0);
    axw(lam_pkg::ADDR_IRQ_ENABLE, 32'h4);
    pinReg.fanFault <= 1'b0;
    for (n = 0; n < 20 && lifeAlarmOutput !== 1'b0; n++) @(posedge clock);
    repeat (2) @(posedge clock);
    chk({31'h0, irq}, 32'h1);
    axr(lam_pkg::ADDR_STATUS, 32'h0);
    axr(lam_pkg::ADDR_IRQ_STATUS, 32'h4);
    axw(lam_pkg::ADDR_IRQ_CLEAR, 32'h4);
    repeat (2) @(posedge clock);
    chk({31'h0, irq}, 32'h0);
    axr(lam_pkg::ADDR_IRQ_STATUS, 32'h0);
    $display("test alarm and interrupt done");
    go <= 1'b1;
    heatsinkTemp <= 8'hF0;
    tick(32'h5A00);
    go <= 1'b0;
    repeat (4) @(posedge clock);
    axr(lam_pkg::ADDR_CTRL_CAP, 32'hA);
    axr(lam_pkg::ADDR_STATUS, 32'h0);
    tick(32'h100);
    repeat (4) @(posedge clock);
    axr(lam_pkg::ADDR_CTRL_CAP, 32'h9);
    axr(lam_pkg::ADDR_STATUS, 32'h1);
    chk({31'h0, lifeAlarmOutput}, 32'h1);
    for (n = 0; n < 50000 && busy; n++) @(posedge clock);
    if (n == 50000) tmo();
    repeat (4) @(posedge clock);
    axr(lam_pkg::ADDR_INRUSH, 32'h63);
    tick(32'hB00);
    repeat (4) @(posedge clock);
    axr(lam_pkg::ADDR_CTRL_CAP, 32'h0);
    $display("test wear counting done");
    axw(lam_pkg::ADDR_MEASURE, 32'h2);
    axr(lam_pkg::ADDR_MEASURE, 32'h0);
    meas(7'h55, 32'h3);
    meas(7'h56, 32'h1);
    $display("test measurement done");
    for (int k = 0; k < 5; k++) begin
      axw(lam_pkg::ADDR_MEASURE, 32'h1);
      pinReg.powerPresent <= 1'b0;
      for (n = 0; n < 20 && dcInjectEnable !== 1'b1; n++) @(posedge clock);
      if (n == 20) tmo();
      case (k)
        0: pinReg.powerPresent <= 1'b1;
        1: pinReg.startCmd <= 1'b1;
        2: pinReg.outputShutoff <= 1'b1;
        3: pinReg.motorConnected <= 1'b0;
        default: pinReg.driveAlarm <= 1'b1;
      endcase
      repeat (6) @(posedge clock);
      axr(lam_pkg::ADDR_MEASURE, (k < 3) ? 32'h8 : 32'h9);
      pinReg <= base;
      repeat (4) @(posedge clock);
    end
    pinReg.motorConnected <= 1'b0;
    axw(lam_pkg::ADDR_MEASURE, 32'h1);
    pinReg.powerPresent <= 1'b0;
    repeat (8) @(posedge clock);
    chk({31'h0, dcInjectEnable}, 32'h0);
    axr(lam_pkg::ADDR_MEASURE, 32'h1);
    pinReg <= base;
    repeat (4) @(posedge clock);
    axw(lam_pkg::ADDR_MEASURE, 32'h1);
    pinReg.powerPresent <= 1'b0;
    for (n = 0; n < 20 && dcInjectEnable !== 1'b1; n++) @(posedge clock);
    if (n == 20) tmo();
    axw(lam_pkg::ADDR_MEASURE, 32'h1);
    axr(lam_pkg::ADDR_MEASURE, 32'h1);
    $display("test disturbed measurement done");
    wrapUp();
  end
endmodule // lam_top_tb_top

/* File: rtl/lam_pkg.sv */
// constants, register map and carrier types of the life alarm monitor
package lam_pkg;
  // timing
  localparam int unsigned CLOCK_HZ          = 32'h017D_7840;
  localparam int unsigned DC_APPLY_TIME_MS  = 32'h0000_03E8;
  localparam int unsigned DC_APPLY_CYCLES   = CLOCK_HZ / 32'h0000_03E8 * DC_APPLY_TIME_MS;
  // life figures
  localparam logic [6:0]  LIFE_FULL         = 7'h64;
  localparam logic [6:0]  INRUSH_ALARM_PCT  = 7'h0A;
  localparam logic [6:0]  CTRL_ALARM_PCT    = 7'h0A;
  localparam logic [6:0]  MAIN_ALARM_PCT    = 7'h55;
  localparam logic [13:0] CLOSURES_PER_PCT  = 14'h2710;
  localparam logic [15:0] CTRL_WEAR_UNIT    = 16'h1000;
  localparam int unsigned TEMP_SHIFT        = 32'h0000_0004;
  // status word bit positions, and bit 4 of the interrupt registers for measurement end
  localparam int unsigned BIT_CTRL          = 32'h0000_0000;
  localparam int unsigned BIT_MAIN          = 32'h0000_0001;
  localparam int unsigned BIT_FAN           = 32'h0000_0002;
  localparam int unsigned BIT_INRUSH        = 32'h0000_0003;
  localparam int unsigned BIT_MEAS_END      = 32'h0000_0004;
  // measurement state codes seen by software
  localparam logic [3:0]  CODE_IDLE         = 4'h0;
  localparam logic [3:0]  CODE_ARMED        = 4'h1;
  localparam logic [3:0]  CODE_RUN          = 4'h2;
  localparam logic [3:0]  CODE_DONE         = 4'h3;
  localparam logic [3:0]  CODE_FORCED       = 4'h8;
  localparam logic [3:0]  CODE_ERROR        = 4'h9;
  // terminal function selections and number of terminals
  localparam logic [7:0]  SEL_SOURCE        = 8'h5A;
  localparam logic [7:0]  SEL_SINK          = 8'hBE;
  localparam int unsigned TERMINALS         = 32'h0000_0003;
  // register byte addresses and bus response codes
  localparam logic [7:0]  ADDR_STATUS       = 8'h00;
  localparam logic [7:0]  ADDR_INRUSH       = 8'h04;
  localparam logic [7:0]  ADDR_CTRL_CAP     = 8'h08;
  localparam logic [7:0]  ADDR_MAIN_CAP     = 8'h0C;
  localparam logic [7:0]  ADDR_MEASURE      = 8'h10;
  localparam logic [7:0]  ADDR_TERM_SEL     = 8'h14;
  localparam logic [7:0]  ADDR_IRQ_STATUS   = 8'h18;
  localparam logic [7:0]  ADDR_IRQ_ENABLE   = 8'h1C;
  localparam logic [7:0]  ADDR_IRQ_CLEAR    = 8'h20;
  localparam logic [1:0]  RESP_OKAY         = 2'h0;
  localparam logic [1:0]  RESP_SLVERR       = 2'h2;

  typedef enum logic [2:0] {MEAS_IDLE, MEAS_ARMED, MEAS_RUN, MEAS_DONE, MEAS_FORCED, MEAS_ERROR} lam_meas_type;

  // pins from the drive, all asynchronous to clock
  typedef struct packed {
    logic inrushContact;
    logic powerPresent;
    logic fanFault;
    logic outputShutoff;
    logic startCmd;
    logic driveAlarm;
    logic motorConnected;
  } lam_pins_type;
endpackage

/* File: rtl/lam_top.sv */
// parts-life supervision with life alarm, capacitor measurement and AXI4-Lite registers
//
// Decided for this implementation: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/1ns
// Function
// - keep 4-bit status: bit3 inrush, bit2 fan, bit1 main cap, bit0 control cap.
// - life alarm output is the OR of the four status bits.
// - terminals selecting 90 get alarm true-high, 190 get it inverted.
// - count inrush closures; life drops one percent per 10,000 closures from 100.
// - inrush life at 10 percent sets status bit 3 and the alarm.
// - control capacitor life falls from 100 with energized time and heatsink temperature.
// - control capacitor life below 10 percent sets status bit 0 and the alarm.
// - completed measurement updates main capacitor life as percent of shipment capacitance.
// - main capacitor life at or below 85 percent sets bit 1 and alarm.
// - measurement codes 0 idle, 1 armed, 2 measuring, 3 done, 8 forced, 9 error.
// - host writes of code 2 are refused; only the device shows it.
// - armed measurement applies DC to the motor for 1 s after power-off.
// - disturbed measurement ends at 8 or 9, or stays at 1.
// - inrush, control and main life figures read 0 to 100, starting at 100.
module lam_top #(
  parameter int unsigned DC_APPLY_CYCLES = lam_pkg::DC_APPLY_CYCLES
) (
  // clock and reset
  input  wire logic                 clock,
  input  wire logic                 rst,
  // AXI4-Lite slave
  input  wire logic [7:0]           s_axi_awaddr,
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  output logic [1:0]                s_axi_bresp,
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  input  wire logic [7:0]           s_axi_araddr,
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  output logic [31:0]               s_axi_rdata,
  output logic [1:0]                s_axi_rresp,
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready,
  // drive pins and on-clock sensors
  input  wire lam_pkg::lam_pins_type pinsAsync,
  input  wire logic [7:0]           heatsinkTemp,
  input  wire logic                 energizeTick,
  input  wire logic [6:0]           capMeasPercent,
  // outputs
  output logic                      lifeAlarmOutput,
  output logic [2:0]                terminalOut,
  output logic                      dcInjectEnable,
  output logic                      irq
);

  function automatic logic addrKnown(input logic [7:0] a);
    addrKnown = (a <= lam_pkg::ADDR_IRQ_CLEAR) && (a[1:0] == 2'h0);
  endfunction

  function automatic logic [3:0] stateCode(input lam_pkg::lam_meas_type s);
    case (s)
      lam_pkg::MEAS_ARMED:  stateCode = lam_pkg::CODE_ARMED;
      lam_pkg::MEAS_RUN:    stateCode = lam_pkg::CODE_RUN;
      lam_pkg::MEAS_DONE:   stateCode = lam_pkg::CODE_DONE;
      lam_pkg::MEAS_FORCED: stateCode = lam_pkg::CODE_FORCED;
      lam_pkg::MEAS_ERROR:  stateCode = lam_pkg::CODE_ERROR;
      default:              stateCode = lam_pkg::CODE_IDLE;
    endcase
  endfunction

  // synchronisers: first stage feeds only the second
  lam_pkg::lam_pins_type pinsMeta, pins, pinsLast;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pinsMeta <= '0;
      pins     <= '0;
      pinsLast <= '0;
    end else begin
      pinsMeta <= pinsAsync;
      pins     <= pinsMeta;
      pinsLast <= pins;
    end
  end

  logic closureRise, powerFall;
  assign closureRise = pins.inrushContact && !pinsLast.inrushContact;
  assign powerFall   = !pins.powerPresent && pinsLast.powerPresent;

  // ---------------- bus state ----------------
  logic        awHeld, wHeld, next_awHeld, next_wHeld;
  logic [7:0]  awAddr, next_awAddr;
  logic [31:0] wData, next_wData;
  logic [3:0]  wStrb, next_wStrb;
  logic        next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
  logic [1:0]  next_bresp, next_rresp;
  logic [31:0] next_rdata;
  logic        doWrite;

  // ---------------- block state ----------------
  logic [6:0]  inrushLife, ctrlLife, mainLife, next_inrushLife, next_ctrlLife, next_mainLife;
  logic [13:0] closureCount, next_closureCount;
  logic [15:0] wearAcc, next_wearAcc;
  logic [3:0]  statusWord, next_statusWord;
  lam_pkg::lam_meas_type meas, next_meas;
  logic [31:0] dcCount, next_dcCount;
  logic [7:0]  termSel [lam_pkg::TERMINALS];
  logic [7:0]  next_termSel [lam_pkg::TERMINALS];
  logic [4:0]  irqStatus, irqEnable, next_irqStatus, next_irqEnable, irqEvents, irqClear;
  logic        next_alarm, next_irq, next_dcInject;
  logic [2:0]  next_terminalOut;
  logic [15:0] wearStep;

  always_comb begin
    next_awHeld  = awHeld;
    next_wHeld   = wHeld;
    next_awAddr  = awAddr;
    next_wData   = wData;
    next_wStrb   = wStrb;
    next_bvalid  = s_axi_bvalid;
    next_bresp   = s_axi_bresp;
    next_rvalid  = s_axi_rvalid;
    next_rdata   = s_axi_rdata;
    next_rresp   = s_axi_rresp;
    if (s_axi_awvalid && s_axi_awready) begin
      next_awHeld = 1'b1;
      next_awAddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_wHeld = 1'b1;
      next_wData = s_axi_wdata;
      next_wStrb = s_axi_wstrb;
    end
    if (s_axi_bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
    doWrite = awHeld && wHeld && !s_axi_bvalid;
    if (doWrite) begin
      next_awHeld = 1'b0;
      next_wHeld  = 1'b0;
      next_bvalid = 1'b1;
      next_bresp  = addrKnown(awAddr) ? lam_pkg::RESP_OKAY : lam_pkg::RESP_SLVERR;
    end
    if (s_axi_rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      next_rvalid = 1'b1;
      next_rresp  = addrKnown(s_axi_araddr) ? lam_pkg::RESP_OKAY : lam_pkg::RESP_SLVERR;
      case (s_axi_araddr)
        lam_pkg::ADDR_STATUS:     next_rdata = {28'h000_0000, statusWord};
        lam_pkg::ADDR_INRUSH:     next_rdata = {25'h000_0000, inrushLife};
        lam_pkg::ADDR_CTRL_CAP:   next_rdata = {25'h000_0000, ctrlLife};
        lam_pkg::ADDR_MAIN_CAP:   next_rdata = {25'h000_0000, mainLife};
        lam_pkg::ADDR_MEASURE:    next_rdata = {28'h000_0000, stateCode(meas)};
        lam_pkg::ADDR_TERM_SEL:   next_rdata = {8'h00, termSel[2], termSel[1], termSel[0]};
        lam_pkg::ADDR_IRQ_STATUS: next_rdata = {27'h000_0000, irqStatus};
        lam_pkg::ADDR_IRQ_ENABLE: next_rdata = {27'h000_0000, irqEnable};
        default:                  next_rdata = 32'h0000_0000;
      endcase
    end
    next_awready = !next_awHeld;
    next_wready  = !next_wHeld;
    next_arready = !next_rvalid;
  end

  // ---------------- life figures, measurement, status ----------------
  always_comb begin
    next_inrushLife   = inrushLife;
    next_closureCount = closureCount;
    next_ctrlLife     = ctrlLife;
    next_wearAcc      = wearAcc;
    next_mainLife     = mainLife;
    next_meas         = meas;
    next_dcCount      = dcCount;
    next_termSel      = termSel;
    next_irqEnable    = irqEnable;
    irqClear          = 5'h00;
    wearStep          = 16'h0001 + 16'(heatsinkTemp >> lam_pkg::TEMP_SHIFT);
    // inrush closures, held at zero life
    if (closureRise && inrushLife != 7'h00) begin
      if (closureCount == lam_pkg::CLOSURES_PER_PCT - 14'h0001) begin
        next_closureCount = 14'h0000;
        next_inrushLife   = inrushLife - 7'h01;
      end else begin
        next_closureCount = closureCount + 14'h0001;
      end
    end
    // hotter heatsink ages the capacitor faster per energized tick
    if (energizeTick && ctrlLife != 7'h00) begin
      if (wearAcc + wearStep >= lam_pkg::CTRL_WEAR_UNIT) begin
        next_wearAcc  = wearAcc + wearStep - lam_pkg::CTRL_WEAR_UNIT;
        next_ctrlLife = ctrlLife - 7'h01;
      end else begin
        next_wearAcc = wearAcc + wearStep;
      end
    end
    case (meas)
      lam_pkg::MEAS_ARMED: begin
        // motor missing at power-off: stay armed, no DC applied
        if (powerFall && pins.motorConnected) begin
          next_dcCount = 32'h0000_0000;
          next_meas    = pins.driveAlarm ? lam_pkg::MEAS_ERROR : lam_pkg::MEAS_RUN;
        end
      end
      lam_pkg::MEAS_RUN: begin
        if (pins.powerPresent || pins.startCmd || pins.outputShutoff) begin
          next_meas = lam_pkg::MEAS_FORCED;
        end else if (pins.driveAlarm || !pins.motorConnected) begin
          next_meas = lam_pkg::MEAS_ERROR;
        end else if (dcCount == DC_APPLY_CYCLES - 1) begin
          next_meas     = lam_pkg::MEAS_DONE;
          next_mainLife = (capMeasPercent > lam_pkg::LIFE_FULL) ? lam_pkg::LIFE_FULL : capMeasPercent;
        end else begin
          next_dcCount = dcCount + 32'h0000_0001;
        end
      end
      lam_pkg::MEAS_IDLE, lam_pkg::MEAS_DONE, lam_pkg::MEAS_FORCED, lam_pkg::MEAS_ERROR: begin
        next_meas = meas;
      end
      default: next_meas = lam_pkg::MEAS_IDLE;
    endcase
    if (doWrite && addrKnown(awAddr)) begin
      case (awAddr)
        lam_pkg::ADDR_MEASURE: begin
          // only idle and start may be written; restart allowed even while stuck at 2
          if (wStrb[0] && wData[3:0] == lam_pkg::CODE_ARMED) begin
            next_meas = lam_pkg::MEAS_ARMED;
          end else if (wStrb[0] && wData[3:0] == lam_pkg::CODE_IDLE) begin
            next_meas = lam_pkg::MEAS_IDLE;
          end
        end
        lam_pkg::ADDR_TERM_SEL: begin
          for (int i = 0; i < lam_pkg::TERMINALS; i++) begin
            if (wStrb[i]) next_termSel[i] = wData[8*i +: 8];
          end
        end
        lam_pkg::ADDR_IRQ_ENABLE: if (wStrb[0]) next_irqEnable = wData[4:0];
        lam_pkg::ADDR_IRQ_CLEAR:  if (wStrb[0]) irqClear = wData[4:0];
        default: irqClear = 5'h00;
      endcase
    end
    next_dcInject = (next_meas == lam_pkg::MEAS_RUN);
    next_statusWord[lam_pkg::BIT_INRUSH] = next_inrushLife <= lam_pkg::INRUSH_ALARM_PCT;
    next_statusWord[lam_pkg::BIT_FAN]    = pins.fanFault;
    next_statusWord[lam_pkg::BIT_MAIN]   = next_mainLife <= lam_pkg::MAIN_ALARM_PCT;
    next_statusWord[lam_pkg::BIT_CTRL]   = next_ctrlLife < lam_pkg::CTRL_ALARM_PCT;
    next_alarm = |next_statusWord;
    for (int i = 0; i < lam_pkg::TERMINALS; i++) begin
      next_terminalOut[i] = (termSel[i] == lam_pkg::SEL_SOURCE) ? next_alarm :
                            (termSel[i] == lam_pkg::SEL_SINK) ? !next_alarm : 1'b0;
    end
    irqEvents = {(meas == lam_pkg::MEAS_RUN) && (next_meas != lam_pkg::MEAS_RUN),
                 next_statusWord & ~statusWord};
    // an event in the clearing cycle survives the clear
    next_irqStatus = (irqStatus & ~irqClear) | irqEvents;
    next_irq       = |(next_irqStatus & next_irqEnable);
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      awHeld          <= 1'b0;
      wHeld           <= 1'b0;
      awAddr          <= 8'h00;
      wData           <= 32'h0000_0000;
      wStrb           <= 4'h0;
      s_axi_awready   <= 1'b0;
      s_axi_wready    <= 1'b0;
      s_axi_bvalid    <= 1'b0;
      s_axi_bresp     <= lam_pkg::RESP_OKAY;
      s_axi_arready   <= 1'b0;
      s_axi_rvalid    <= 1'b0;
      s_axi_rdata     <= 32'h0000_0000;
      s_axi_rresp     <= lam_pkg::RESP_OKAY;
      inrushLife      <= lam_pkg::LIFE_FULL;
      ctrlLife        <= lam_pkg::LIFE_FULL;
      mainLife        <= lam_pkg::LIFE_FULL;
      closureCount    <= 14'h0000;
      wearAcc         <= 16'h0000;
      statusWord      <= 4'h0;
      meas            <= lam_pkg::MEAS_IDLE;
      dcCount         <= 32'h0000_0000;
      termSel         <= '{default: 8'h00};
      irqStatus       <= 5'h00;
      irqEnable       <= 5'h00;
      lifeAlarmOutput <= 1'b0;
      terminalOut     <= 3'h0;
      dcInjectEnable  <= 1'b0;
      irq             <= 1'b0;
    end else begin
      awHeld          <= next_awHeld;
      wHeld           <= next_wHeld;
      awAddr          <= next_awAddr;
      wData           <= next_wData;
      wStrb           <= next_wStrb;
      s_axi_awready   <= next_awready;
      s_axi_wready    <= next_wready;
      s_axi_bvalid    <= next_bvalid;
      s_axi_bresp     <= next_bresp;
      s_axi_arready   <= next_arready;
      s_axi_rvalid    <= next_rvalid;
      s_axi_rdata     <= next_rdata;
      s_axi_rresp     <= next_rresp;
      inrushLife      <= next_inrushLife;
      ctrlLife        <= next_ctrlLife;
      mainLife        <= next_mainLife;
      closureCount    <= next_closureCount;
      wearAcc         <= next_wearAcc;
      statusWord      <= next_statusWord;
      meas            <= next_meas;
      dcCount         <= next_dcCount;
      termSel         <= next_termSel;
      irqStatus       <= next_irqStatus;
      irqEnable       <= next_irqEnable;
      lifeAlarmOutput <= next_alarm;
      terminalOut     <= next_terminalOut;
      dcInjectEnable  <= next_dcInject;
      irq             <= next_irq;
    end
  end

  // ---------------- assertions ----------------
  a_alarm_is_or: assert property (@(posedge clock) disable iff (rst)
    lifeAlarmOutput == |statusWord) else $error("alarm output differs from OR of status");
  a_inrush_bit_set: assert property (@(posedge clock) disable iff (rst)
    statusWord[lam_pkg::BIT_INRUSH] == (inrushLife <= lam_pkg::INRUSH_ALARM_PCT)) else $error("inrush status bit wrong");
  a_ctrl_bit_set: assert property (@(posedge clock) disable iff (rst)
    (ctrlLife == 7'h0A && $past(ctrlLife) == 7'h0B) |-> !statusWord[0]) else $error("ctrl bit set at 10");
  a_main_bit_set: assert property (@(posedge clock) disable iff (rst)
    $changed(mainLife) |-> statusWord[lam_pkg::BIT_MAIN] == (mainLife <= lam_pkg::MAIN_ALARM_PCT)) else $error("main cap bit wrong");
  a_inrush_step: assert property (@(posedge clock) disable iff (rst)
    (closureRise && closureCount == lam_pkg::CLOSURES_PER_PCT - 14'h0001 && inrushLife != 7'h00)
    |=> inrushLife == $past(inrushLife) - 7'h01)
    else $error("inrush life did not drop after 10000 closures");
  a_life_floor: assert property (@(posedge clock) disable iff (rst)
    (inrushLife == 7'h00) |=> (inrushLife == 7'h00)[*2]) else $error("inrush life wrapped");
  a_code_two_refused: assert property (@(posedge clock) disable iff (rst)
    (doWrite && awAddr == lam_pkg::ADDR_MEASURE && wData[3:0] == lam_pkg::CODE_RUN && meas == lam_pkg::MEAS_IDLE)
    |=> meas == lam_pkg::MEAS_IDLE) else $error("code 2 was accepted from host");
  a_dc_full_time: assert property (@(posedge clock) disable iff (rst)
    $rose(meas == lam_pkg::MEAS_DONE) |-> $past(dcCount) == DC_APPLY_CYCLES - 1 && $past(dcInjectEnable))
    else $error("measurement finished without full DC time");
  a_sink_polarity: assert property (@(posedge clock) disable iff (rst)
    (termSel[0] == lam_pkg::SEL_SINK && $stable(termSel[0])) |-> terminalOut[0] == !lifeAlarmOutput)
    else $error("sink terminal polarity wrong");
  a_meas_disturbed: assert property (@(posedge clock) disable iff (rst)
    (meas == lam_pkg::MEAS_RUN && pins.startCmd) |=> meas == lam_pkg::MEAS_FORCED)
    else $error("start command did not force end");

endmodule // lam_top
